// ===== core/dds_tuning_bank.sv
/*
  Tuning-word bank of a direct digital synthesiser: two frequency
  words, two phase offsets, control word, register selection,
  phase accumulator and its reset/release sequence.
  Assumes the host drives the link and pins from flops on hclk.
*/
`timescale 1ns/10ps

// How it works
// - Two 28-bit frequency, two 12-bit phase registers
// - Accumulator step is selected tuning word
// - Selected phase offset shifts output phase
// - Source bit picks frequency pin or bit
// - Source bit picks phase pin or bit
// - Source may change at any time
// - Select pins sampled, one cycle uncertainty
// - Host keeps select pins steady
// - Address 01 frequency zero, 10 one
// - Full load: low half then high
// - Host alternates registers for sweeps
// - Half mode: half bit picks half
// - Address 11 loads phase, bit 13 picks
// - Reset clears accumulator, keeps registers
// - Output returns seven cycles after release
// - Host applies reset after power-up
// - Address 00 is control word
// - Full load commits after second half
// - Full load ignores half select bit
// - Source bit picks reset pin or bit
module dds_tuning_bank (
  // Clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // Link from the host
  dds_link_if.device                      link,
  // Synthesis outputs
  output logic [dds_pkg::FREQ_W-1:0]      selected_tuning_value,
  output logic [dds_pkg::PHASE_W-1:0]     selected_offset_value,
  output logic [dds_pkg::PHASE_W-1:0]     phase_word,
  output logic                            output_valid,
  output logic [dds_pkg::HALF_W-1:0]      control_word
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  logic [2:0]                    pin_meta_ff;
  logic [2:0]                    pin_sync_ff;
  logic                          word_valid;
  logic [dds_pkg::WORD_W-1:0]    word;
  logic [dds_pkg::HALF_W-1:0]    ctrl_ff;
  logic [dds_pkg::FREQ_W-1:0]    freq_ff [2];
  logic [dds_pkg::PHASE_W-1:0]   phase_ff [2];
  logic [dds_pkg::HALF_W-1:0]    stash_ff;
  logic                          pend_ff;
  logic                          pend_idx_ff;
  logic [dds_pkg::FREQ_W-1:0]    tune_ff;
  logic [dds_pkg::PHASE_W-1:0]   offs_ff;
  logic [dds_pkg::FREQ_W-1:0]    acc_ff;
  logic [dds_pkg::PHASE_W-1:0]   phase_out_ff;
  logic                          valid_ff;
  logic [2:0]                    rel_cnt_ff;
  logic [1:0]                    waddr;
  logic                          fidx;
  logic                          freq_wr;
  logic                          full_mode;
  logic                          same_reg;
  logic                          frequency_select_bit;
  logic                          psel;
  logic                          acc_rst;
  logic                          released;

  // Pick the pin level or the control bit
  function automatic logic pick(input logic use_pin, input logic pin, input logic bit_v);
    pick = use_pin ? pin : bit_v;
  endfunction

  // --------------------------------------------------------------
  // Serial receiver and pin synchronisers
  // --------------------------------------------------------------
  dds_word_shifter u_shifter (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sclk_pin    (link.sclk),
    .fsync_n_pin (link.fsync_n),
    .serial_input_line_pin   (link.serial_input_line),
    .word_valid  (word_valid),
    .word        (word)
  );

  // pins sampled twice
  // Two flops stand in for the falling-edge sample; a pin moving
  // near the edge lands one cycle early or late.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {link.accum_reset_pin, link.phase_select_pin,
                      link.frequency_select_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // --------------------------------------------------------------
  // Word decode
  // --------------------------------------------------------------
  assign waddr     = word[dds_pkg::WORD_W-1 -: 2];
  assign fidx      = (waddr == dds_pkg::ADDR_FREQUENCY_WORD_ONE);
  assign freq_wr   = word_valid & ((waddr == dds_pkg::ADDR_FREQUENCY_WORD_ZERO) |
                                   (waddr == dds_pkg::ADDR_FREQUENCY_WORD_ONE));
  assign full_mode = ctrl_ff[dds_pkg::BIT_FULL_LOAD];
  assign same_reg  = pend_ff & (pend_idx_ff == fidx);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= dds_pkg::CTRL_RESET;
    end else if (word_valid && waddr == dds_pkg::ADDR_CTRL) begin
      ctrl_ff <= word[dds_pkg::HALF_W-1:0];
    end
  end

  // low half waits for high half
  // A mismatched address restarts the pair rather than mixing halves.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff     <= 1'b0;
      pend_idx_ff <= 1'b0;
      stash_ff    <= 14'h0000;
    end else if (freq_wr && full_mode) begin
      pend_ff <= ~same_reg;
      if (!same_reg) begin
        pend_idx_ff <= fidx;
        stash_ff    <= word[dds_pkg::HALF_W-1:0];
      end
    end else if (word_valid && waddr == dds_pkg::ADDR_CTRL
                 && !word[dds_pkg::BIT_FULL_LOAD]) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_ff[0] <= 28'h000_0000;
      freq_ff[1] <= 28'h000_0000;
    end else if (freq_wr) begin
      if (full_mode) begin
        if (same_reg) begin
          freq_ff[fidx] <= {word[dds_pkg::HALF_W-1:0], stash_ff};
        end
      end else if (ctrl_ff[dds_pkg::BIT_HALF_SEL]) begin
        freq_ff[fidx][dds_pkg::FREQ_W-1:dds_pkg::HALF_W] <= word[dds_pkg::HALF_W-1:0];
      end else begin
        freq_ff[fidx][dds_pkg::HALF_W-1:0] <= word[dds_pkg::HALF_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff[0] <= 12'h000;
      phase_ff[1] <= 12'h000;
    end else if (word_valid && waddr == dds_pkg::ADDR_PHASE) begin
      phase_ff[word[dds_pkg::BIT_PHASE_REG]] <= word[dds_pkg::PHASE_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // Register selection
  // --------------------------------------------------------------
  // frequency source choice
  assign frequency_select_bit = pick(ctrl_ff[dds_pkg::BIT_SOURCE], pin_sync_ff[0],
                     ctrl_ff[dds_pkg::BIT_FREQ_SEL]);
  assign psel = pick(ctrl_ff[dds_pkg::BIT_SOURCE], pin_sync_ff[1],
                     ctrl_ff[dds_pkg::BIT_PHASE_SEL]);
  assign acc_rst = pick(ctrl_ff[dds_pkg::BIT_SOURCE], pin_sync_ff[2],
                        ctrl_ff[dds_pkg::BIT_RESET]);

  // reselect every cycle
  // No handover state: a source flip simply steers the next sample.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tune_ff <= 28'h000_0000;
      offs_ff <= 12'h000;
    end else begin
      tune_ff <= freq_ff[frequency_select_bit];
      offs_ff <= phase_ff[psel];
    end
  end

  // --------------------------------------------------------------
  // Accumulator and release sequence
  // --------------------------------------------------------------
  // release countdown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rel_cnt_ff <= dds_pkg::RELEASE_CYCLES;
    end else if (acc_rst) begin
      rel_cnt_ff <= dds_pkg::RELEASE_CYCLES;
    end else if (rel_cnt_ff != 3'h0) begin
      rel_cnt_ff <= rel_cnt_ff - 3'h1;
    end
  end

  assign released = ~acc_rst & (rel_cnt_ff <= 3'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 28'h000_0000;
    end else if (acc_rst) begin
      acc_ff <= 28'h000_0000;
    end else begin
      acc_ff <= dds_pkg::FREQ_W'(acc_ff + tune_ff);
    end
  end

  // offset added to top bits
  // Output phase held at zero (midscale) until the release count ends.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_out_ff <= 12'h000;
      valid_ff     <= 1'b0;
    end else begin
      valid_ff     <= released;
      phase_out_ff <= released ?
                      dds_pkg::PHASE_W'(acc_ff[dds_pkg::FREQ_W-1:dds_pkg::ACC_TOP]
                                        + offs_ff) : 12'h000;
    end
  end

  // Outputs straight from flops
  assign selected_tuning_value = tune_ff;
  assign selected_offset_value = offs_ff;
  assign phase_word            = phase_out_ff;
  assign output_valid          = valid_ff;
  assign control_word          = ctrl_ff;

endmodule // dds_tuning_bank

// ===== shared/dds_pkg.sv
/*
  Shared constants for the tuning-word bank and its serial host:
  word layout, control bit positions, link timing, host register map.
  Assumes one 100 MHz clock on both ends.
*/
package dds_pkg;

  // ----------------------------------------------------------------
  // Word and register layout
  // ----------------------------------------------------------------
  localparam int FREQ_W  = 28;
  localparam int PHASE_W = 12;
  localparam int WORD_W  = 16;
  localparam int HALF_W  = 14;
  localparam int ACC_TOP = FREQ_W - PHASE_W;

  // Top two bits of a serial word
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_FREQUENCY_WORD_ZERO = 2'h1;
  localparam logic [1:0] ADDR_FREQUENCY_WORD_ONE = 2'h2;
  localparam logic [1:0] ADDR_PHASE = 2'h3;

  // Control word bit positions
  localparam int BIT_FULL_LOAD = 13;
  localparam int BIT_HALF_SEL  = 12;
  localparam int BIT_FREQ_SEL  = 11;
  localparam int BIT_PHASE_SEL = 10;
  localparam int BIT_SOURCE    = 9;
  localparam int BIT_RESET     = 8;
  localparam int BIT_PHASE_REG = 13;

  // Control register comes up with the accumulator reset bit set
  localparam logic [HALF_W-1:0] CTRL_RESET = 14'h0100;

  // Output appears this many cycles after accumulator reset release
  localparam logic [2:0] RELEASE_CYCLES = 3'h7;

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS  = 40;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LAST_BIT = 4'hf;

  // ----------------------------------------------------------------
  // Host register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SEND   = 8'h00;
  localparam logic [7:0] REG_PINS   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int PIN_FREQUENCY_SELECT_BIT  = 0;
  localparam int PIN_PSEL  = 1;
  localparam int PIN_RESET = 2;
  localparam logic [2:0] PINS_RESET = 3'h4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_GAP} link_state_e;

endpackage

// ===== shared/dds_link_if.sv
/*
  Three-wire serial link plus select and reset pins between the
  host controller and the tuning-word bank. Both ends share hclk.
*/
`timescale 1ns/10ps
interface dds_link_if;
  logic sclk;
  logic fsync_n;
  logic serial_input_line;
  logic frequency_select_pin;
  logic phase_select_pin;
  logic accum_reset_pin;

  modport host (
    output sclk, fsync_n, serial_input_line,
    output frequency_select_pin, phase_select_pin, accum_reset_pin
  );
  modport device (
    input  sclk, fsync_n, serial_input_line,
    input  frequency_select_pin, phase_select_pin, accum_reset_pin
  );
endinterface

// ===== core/dds_word_shifter.sv
/*
  Serial word receiver: synchronises the three link wires and
  collects 16 bits on falling clock edges while the frame is low.
  Assumes the link clock is much slower than hclk.
*/
`timescale 1ns/10ps
module dds_word_shifter (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // Raw link wires
  input  wire logic                      sclk_pin,
  input  wire logic                      fsync_n_pin,
  input  wire logic                      serial_input_line_pin,
  // Received word
  output logic                           word_valid,
  output logic [dds_pkg::WORD_W-1:0]     word
);

  logic [2:0]                  meta_ff;
  logic [2:0]                  sync_ff;
  logic                        sclk_d_ff;
  logic [3:0]                  cnt_ff;
  logic [dds_pkg::WORD_W-1:0]  shift_ff;
  logic                        valid_ff;
  logic                        fall;

  // --------------------------------------------------------------
  // Two-stage synchronisers; only sync_ff is looked at
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff   <= 3'h7;
      sync_ff   <= 3'h7;
      sclk_d_ff <= 1'b1;
    end else begin
      meta_ff   <= {sclk_pin, fsync_n_pin, serial_input_line_pin};
      sync_ff   <= meta_ff;
      sclk_d_ff <= sync_ff[2];
    end
  end

  assign fall = sclk_d_ff & ~sync_ff[2];

  // Shift on falling edge inside a frame; frame high restarts count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff   <= 4'h0;
      shift_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      if (sync_ff[1]) begin
        cnt_ff <= 4'h0;
      end else if (fall) begin
        shift_ff <= {shift_ff[dds_pkg::WORD_W-2:0], sync_ff[0]};
        cnt_ff   <= cnt_ff + 4'h1;
        valid_ff <= (cnt_ff == dds_pkg::LAST_BIT);
      end
    end
  end

  assign word_valid = valid_ff;
  assign word       = shift_ff;

endmodule // dds_word_shifter

// ===== core/dds_serial_host.sv
/*
  Host controller: AHB-Lite slave registers, serial word sender and
  select/reset pin drivers for the tuning-word bank.
  Assumes a single AHB-Lite master and the bank on the same hclk.
*/
`timescale 1ns/10ps
module dds_serial_host (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic [2:0]        hsize,
  input  wire logic              hwrite,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Link to the bank
  dds_link_if.host               link
);

  logic [7:0]                   addr_ff;
  logic                         wr_ff;
  logic [31:0]                  rdata_ff;
  logic [2:0]                   pins_ff;
  dds_pkg::link_state_e         state_ff;
  logic [dds_pkg::WORD_W-1:0]   shift_ff;
  logic [3:0]                   bit_cnt_ff;
  logic [7:0]                   div_ff;
  logic                         sclk_ff;
  logic                         fsync_n_ff;
  logic                         tick;
  logic                         start;
  logic                         busy;

  // --------------------------------------------------------------
  // Bus slave, zero wait states
  // --------------------------------------------------------------
  assign busy = (state_ff != dds_pkg::LINK_IDLE);

  // Address phase capture; read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff  <= 8'h00;
      wr_ff    <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wr_ff <= 1'b0;
      if (hsel && hready && htrans == dds_pkg::HTRANS_NONSEQ) begin
        addr_ff <= haddr[7:0];
        wr_ff   <= hwrite;
        if (!hwrite) begin
          unique case (haddr[7:0])
            dds_pkg::REG_PINS:   rdata_ff <= {29'h0000_0000, pins_ff};
            dds_pkg::REG_STATUS: rdata_ff <= {31'h0000_0000, busy};
            default:             rdata_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // pins change only on a register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_ff <= dds_pkg::PINS_RESET;
    end else if (wr_ff && addr_ff == dds_pkg::REG_PINS) begin
      pins_ff <= hwdata[2:0];
    end
  end

  // --------------------------------------------------------------
  // Serial sender
  // --------------------------------------------------------------
  // A send while busy is dropped; software polls the busy bit.
  assign start = wr_ff && addr_ff == dds_pkg::REG_SEND && !busy;
  assign tick  = (div_ff == 8'h00);

  // Half-period divider, restarted with each frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 8'h00;
    end else if (start || tick) begin
      div_ff <= 8'(dds_pkg::SCLK_HALF_CYC - 1);
    end else begin
      div_ff <= div_ff - 8'h01;
    end
  end

  // words sent whole, in order, MSB first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= dds_pkg::LINK_IDLE;
      shift_ff   <= 16'h0000;
      bit_cnt_ff <= 4'h0;
      sclk_ff    <= 1'b1;
      fsync_n_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        dds_pkg::LINK_IDLE: begin
          if (start) begin
            shift_ff   <= hwdata[dds_pkg::WORD_W-1:0];
            bit_cnt_ff <= dds_pkg::LAST_BIT;
            fsync_n_ff <= 1'b0;
            state_ff   <= dds_pkg::LINK_SHIFT;
          end
        end
        dds_pkg::LINK_SHIFT: begin
          if (tick) begin
            if (sclk_ff) begin
              sclk_ff <= 1'b0;
            end else if (bit_cnt_ff == 4'h0) begin
              sclk_ff    <= 1'b1;
              fsync_n_ff <= 1'b1;
              state_ff   <= dds_pkg::LINK_GAP;
            end else begin
              sclk_ff    <= 1'b1;
              bit_cnt_ff <= bit_cnt_ff - 4'h1;
              shift_ff   <= {shift_ff[dds_pkg::WORD_W-2:0], 1'b0};
            end
          end
        end
        dds_pkg::LINK_GAP: begin
          if (tick) begin
            state_ff <= dds_pkg::LINK_IDLE;
            shift_ff <= 16'h0000;
          end
        end
      endcase
    end
  end

  // Outputs straight from flops; hreadyout and hresp are tied to constants
  assign hrdata                    = rdata_ff;
  assign hreadyout                 = 1'b1;
  assign hresp                     = dds_pkg::HRESP_OKAY;
  assign link.sclk                 = sclk_ff;
  assign link.fsync_n              = fsync_n_ff;
  assign link.serial_input_line    = shift_ff[dds_pkg::WORD_W-1];
  assign link.frequency_select_pin = pins_ff[dds_pkg::PIN_FREQUENCY_SELECT_BIT];
  assign link.phase_select_pin     = pins_ff[dds_pkg::PIN_PSEL];
  assign link.accum_reset_pin      = pins_ff[dds_pkg::PIN_RESET];

endmodule // dds_serial_host

// ===== bench/dds_tuning_word_bank_chk.sv
/*
  Checker for the serial link wires and the bank outputs.
  Instantiated beside the link interface; one hclk domain.
*/
`timescale 1ns/10ps
module dds_tuning_word_bank_chk (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Link wires
  input  wire logic        sclk,
  input  wire logic        fsync_n,
  input  wire logic        serial_input_line,
  input  wire logic        accum_reset_pin,
  // Bank outputs
  input  wire logic [13:0] control_word,
  input  wire logic [27:0] selected_tuning_value,
  input  wire logic [11:0] selected_offset_value,
  input  wire logic [11:0] phase_word,
  input  wire logic        output_valid
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Falling link edges in the current frame
  logic [4:0] falls_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) falls_ff <= 5'h00;
    else if (fsync_n) falls_ff <= 5'h00;
    else if ($fell(sclk)) falls_ff <= falls_ff + 5'h01;
  end

  // ----------------------------------------------------------------
  // Link wire checks
  // ----------------------------------------------------------------
  property p_sclk_idle;
    fsync_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("link clock low outside frame");
  property p_data_stable;
    !sclk |-> $stable(serial_input_line);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved in low clock");
  property p_frame_bits;
    $rose(fsync_n) |-> falls_ff == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame not sixteen bits");

  // ----------------------------------------------------------------
  // Bank output checks
  // ----------------------------------------------------------------
  property p_bit_hold;
    (!control_word[9] && control_word[8])[*2] |-> !output_valid && phase_word == 12'h000;
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("output live under bit reset");
  property p_release;
    $fell(control_word[8]) && !control_word[9] |-> (!output_valid)[*6] ##[1:3] output_valid;
  endproperty
  a_release: assert property (p_release) else $error("release timing wrong");
  property p_pin_rst;
    (control_word[9] && accum_reset_pin)[*4] |-> !output_valid;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("output live under pin reset");
  // Zero step freezes the phase once the pipe has flushed
  property p_zero_step;
    (output_valid && selected_tuning_value == 28'h0 && $stable(selected_offset_value))[*4]
      |-> $stable(phase_word);
  endproperty
  a_zero_step: assert property (p_zero_step) else $error("phase moved at zero step");
  property p_ctrl_frame;
    $changed(control_word) |-> $past(fsync_n, 5) == 1'b0;
  endproperty
  a_ctrl_frame: assert property (p_ctrl_frame) else $error("control changed off frame");
endmodule // dds_tuning_word_bank_chk

// ===== bench/dds_tuning_word_bank_bench.sv
/*
  Bench: AHB-Lite master drives the host, which feeds the bank.
  Assumes single 100 MHz clock and the package constants.
*/
`timescale 1ns/10ps
module dds_tuning_word_bank_bench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [27:0] selected_tuning_value;
  logic [11:0] selected_offset_value;
  logic [11:0] phase_word;
  logic        output_valid;
  logic [13:0] control_word;
  logic [27:0] f [2];
  logic [11:0] p [2];
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] r;
  logic        s;
  int          err_total;
  int          total_checks;

  dds_link_if dds_link_if_i ();
  dds_serial_host dds_serial_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(dds_link_if_i.host));
  dds_tuning_bank dds_tuning_bank_i (.hclk(hclk), .hresetn(hresetn),
    .link(dds_link_if_i.device), .selected_tuning_value(selected_tuning_value),
    .selected_offset_value(selected_offset_value), .phase_word(phase_word),
    .output_valid(output_valid), .control_word(control_word));
  dds_tuning_word_bank_chk dds_tuning_word_bank_chk_i (.hclk(hclk), .hresetn(hresetn),
    .sclk(dds_link_if_i.sclk), .fsync_n(dds_link_if_i.fsync_n),
    .serial_input_line(dds_link_if_i.serial_input_line),
    .accum_reset_pin(dds_link_if_i.accum_reset_pin), .control_word(control_word),
    .selected_tuning_value(selected_tuning_value), .selected_offset_value(selected_offset_value),
    .phase_word(phase_word), .output_valid(output_valid));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected word after a half write
  function automatic logic [27:0] upd(logic [27:0] old, logic [13:0] d, logic hi);
    return hi ? {d, old[13:0]} : {old[27:14], d};
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounded wait for the slave answer
  task automatic rdy();
    int n = 0;
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer, address then data phase
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] q);
    htrans <= dds_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge hclk);
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    rdy();
    q = hrdata;
  endtask

  // Send a word, poll busy until clear
  task automatic send(logic [15:0] w);
    int n;
    ahb(1'b1, dds_pkg::REG_SEND, {16'h0000, w}, rd);
    rd = 32'h0000_0001;
    n = 0;
    while (rd[0] !== 1'b0) begin
      n++;
      if (n > 100) begin
        err_total++;
        finish_test();
      end
      ahb(1'b0, dds_pkg::REG_STATUS, 32'h0, rd);
    end
  endtask

  task automatic wait_valid();
    for (int n = 0; output_valid !== 1'b1; n++) begin
      if (n > 30) begin
        err_total++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwrite = 1'b0;
    hwdata = 32'h0;
    seed = 32'h0000_b3c6;
    err_total = 0;
    total_checks = 0;
    f = '{28'h0, 28'h0};
    p = '{12'h0, 12'h0};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("ctrl", control_word, 14'h0100);
    check("valid", output_valid, 1'b0);
    ahb(1'b0, dds_pkg::REG_PINS, 32'h0, rd);
    check("pins", rd, 32'h0000_0004);
    ahb(1'b1, 8'h0c, 32'hffff_ffff, rd);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    check("resp", hresp, 1'b0);
    send(16'h0000);
    wait_valid();
    check("release", output_valid, 1'b1);
    $display("test reset done");
    // Full loads with a random, ignored half select
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      s = i[0];
      send({3'b001, r[31], s, 11'h000});
      send({s, ~s, r[13:0]});
      check("pending", selected_tuning_value, f[s]);
      send({s, ~s, r[27:14]});
      f[s] = r[27:0];
      check("full", selected_tuning_value, f[s]);
    end
    $display("test full load done");
    // Half loads, both halves of both words
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      s = i[0];
      send({3'b000, i[1], s, 11'h000});
      send({s, ~s, r[13:0]});
      f[s] = upd(f[s], r[13:0], i[1]);
      check("half", selected_tuning_value, f[s]);
    end
    // Phase offsets with random don't-care bit
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      s = i[0];
      send({5'b00000, s, 10'h000});
      send({2'b11, s, r[12], r[11:0]});
      p[s] = r[11:0];
      check("phase", selected_offset_value, p[s]);
    end
    $display("test half and phase done");
    // Pin selection; reset pin lowered first
    ahb(1'b1, dds_pkg::REG_PINS, 32'h0, rd);
    send(16'h0200);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, dds_pkg::REG_PINS, {30'h0, i[1:0]}, rd);
      repeat (5) @(posedge hclk);
      check("pin freq", selected_tuning_value, f[i[0]]);
      check("pin phase", selected_offset_value, p[i[1]]);
    end
    ahb(1'b1, dds_pkg::REG_PINS, 32'h0000_0007, rd);
    repeat (5) @(posedge hclk);
    check("pin reset", output_valid, 1'b0);
    check("kept", selected_tuning_value, f[1]);
    ahb(1'b1, dds_pkg::REG_PINS, 32'h0, rd);
    wait_valid();
    check("pin release", output_valid, 1'b1);
    // Back to bit control under the reset bit
    send(16'h0100);
    check("bit reset", output_valid, 1'b0);
    check("bit phase", selected_offset_value, p[0]);
    send(16'h0000);
    wait_valid();
    check("bit release", output_valid, 1'b1);
    $display("test select done");
    finish_test();
  end
endmodule // dds_tuning_word_bank_bench
